// File: src/gia_pkg.sv
// constants for the pin event and alternate input block
package gia_pkg;

    localparam int NPINS = 13;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS   = 8'h1E;
    localparam logic [7:0] IDX_MASK     = 8'h26;
    localparam logic [7:0] IDX_EDGEMODE = 8'h20;
    localparam logic [7:0] IDX_POLARITY = 8'h21;
    localparam logic [7:0] IDX_DIR      = 8'h22;
    localparam logic [7:0] IDX_LEVEL    = 8'h23;
    localparam logic [7:0] IDX_FN_LO    = 8'h24;
    localparam logic [7:0] IDX_FN_HI    = 8'h25;
    localparam logic [7:0] IDX_CTRL     = 8'h27;
    localparam logic [7:0] IDX_ALTSTATE = 8'h28;

    // reset values
    localparam logic [12:0] RST_MASK     = 13'h1FFF;
    localparam logic [12:0] RST_EDGEMODE = 13'h0000;
    localparam logic [12:0] RST_POLARITY = 13'h1FFF;
    localparam logic [12:0] RST_DIR      = 13'h1FFF;
    localparam logic [12:0] RST_LEVEL    = 13'h0000;
    localparam logic [3:0]  RST_CTRL     = 4'h0;

    // control register bit positions
    localparam int CTRL_FULLRST_EN = 0;
    localparam int CTRL_CPORT_4W   = 1;
    localparam int CTRL_SINK_STRB  = 2;
    localparam int CTRL_SINK_TRGIO = 3;

    // fixed pins for routed functions
    localparam int PIN_ADC_FRAME = 5;
    localparam int PIN_ADC_BIT_A = 6;
    localparam int PIN_ADC_BIT_B = 8;
    localparam int PIN_CPORT_SEL = 7;

    // pin function select codes, four bits per pin
    localparam int FN_W = 4;
    localparam logic [3:0] FN_GPIO     = 4'h0;
    localparam logic [3:0] FN_ADC_FRM  = 4'h1;
    localparam logic [3:0] FN_ADC_BIT  = 4'h2;
    localparam logic [3:0] FN_FULLRST  = 4'h3;
    localparam logic [3:0] FN_STROBE   = 4'h4;
    localparam logic [3:0] FN_HIB_LVL  = 4'h5;
    localparam logic [3:0] FN_HIB_EDGE = 4'h6;
    localparam logic [3:0] FN_WDOG     = 4'h7;
    localparam logic [3:0] FN_REG1_EN  = 4'h8;
    localparam logic [3:0] FN_LOWPWR1  = 4'h9;
    localparam logic [3:0] FN_LOWPWR2  = 4'hA;
    localparam logic [3:0] FN_LOWPWR3  = 4'hB;
    localparam logic [3:0] FN_AUXGATE  = 4'hC;
    localparam logic [3:0] FN_MANRST   = 4'hD;
    localparam logic [3:0] FN_SHUTDOWN = 4'hE;
    localparam logic [3:0] FN_PWRUP    = 4'hF;

endpackage

// File: src/gia_core.sv
// pin event flags, interrupt aggregation and alternate input routing
// Summary of operation
// (R1) interrupt output is OR of all unmasked pin event flags
// (R2) thirteen sticky flags in status register, cleared when software reads them
// (R3) a mask bit of one keeps its flag off the interrupt
// (R4) flag sets on rising edge, or both edges when edge mode is one
// (R5) writing zero to an input pin's level bit clears its flag
// (R6) polarity select applied before edge detection and alternate functions
// (R7) adc frame clock alternate taken from pin 5, shared pin then dac only
// (R8) adc bit clock alternate taken from pin 6 or 8, shared pin dac only
// (R9) full reset input requests complete reset and restart per config mode
// (R10) software sets full reset enable before using full reset input
// (R11) in 3/4-wire mode pin 7 is control port select regardless of function
// (R12) strobe trigger acts on rising edge, only with sink a strobe and gpio trigger
// (R13) level hibernate input asserted while active after polarity
// (R14) edge hibernate entered on rising edge after polarity
// (R15) edge-entered hibernate holds until a start-up event
// (R16) watchdog kick delivered as rising edge pulses only
// (R17) manual reset drives reset outputs low, nothing else
// (R18) three low power requests routed to power sequencer
// (R19) shutdown request routed to sequencer for controlled power-down
// (R20) aux converter gating input routed to auxiliary converter
// (R21) regulator one enable input routed to regulator one
// (R22) power up request routed to sequencer as power-on request
// (R23) pins synchronised before edge detection; flags sticky until cleared
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module gia_core #(
    parameter int NPINS = gia_pkg::NPINS
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [9:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // pins
    input  wire logic [NPINS-1:0]  pinIn,
    output logic [NPINS-1:0]       pinOut,
    output logic [NPINS-1:0]       pinOe,
    // events from other units, same clock
    input  wire logic              startupEvent,
    // outputs to other units
    output logic                   gpioInt,
    output logic                   adcFrameClockAlt,
    output logic                   adcFrameClockSel,
    output logic                   adcBitClockAlt,
    output logic                   adcBitClockSel,
    output logic                   fullResetRequest,
    output logic                   controlPortSelect,
    output logic                   strobeStart,
    output logic                   hibernateRequest,
    output logic                   watchdogKick,
    output logic                   regulatorOneEnable,
    output logic [2:0]             lowPowerRequest,
    output logic                   shutdownRequest,
    output logic                   powerUpRequest,
    output logic                   auxConverterGate,
    output logic                   resetOutputs_n
);

    typedef struct packed {
        logic [NPINS-1:0]        syncA;
        logic [NPINS-1:0]        syncB;
        logic [NPINS-1:0]        prevCond;
        logic [NPINS-1:0]        flag;
        logic [NPINS-1:0]        mask;
        logic [NPINS-1:0]        edgeMode;
        logic [NPINS-1:0]        polarity;
        logic [NPINS-1:0]        dir;
        logic [NPINS-1:0]        level;
        logic [NPINS*4-1:0]      fnSel;
        logic [3:0]              ctrl;
        logic                    prevStrobe;
        logic                    prevHibEdge;
        logic                    prevWdog;
        logic                    hibLatched;
        logic                    pready;
        logic                    pslverr;
        logic [31:0]             prdata;
        logic                    gpioInt;
        logic                    adcFrm;
        logic                    adcFrmSel;
        logic                    adcBit;
        logic                    adcBitSel;
        logic                    fullRst;
        logic                    cportSel;
        logic                    strobe;
        logic                    hib;
        logic                    wdog;
        logic                    reg1En;
        logic [2:0]              lowPwr;
        logic                    shutdown;
        logic                    pwrUp;
        logic                    auxGate;
        logic                    rstOut_n;
        logic [NPINS-1:0]        pinOut;
        logic [NPINS-1:0]        pinOe;
    } gia_state_t;

    gia_state_t state_reg;
    gia_state_t state_next;

    // level of one alternate function: OR of every input pin selecting it, except pin 7 in 3/4-wire mode
    function automatic logic alt_level(
        input logic [3:0]        code,
        input logic [NPINS*4-1:0] fn,
        input logic [NPINS-1:0]  isIn,
        input logic [NPINS-1:0]  cond,
        input logic              cport4w
    );
        logic acc;
        acc = 1'b0;
        for (int i = 0; i < NPINS; i++)
        begin
            // pin 7 is taken over by the control port in 3/4-wire mode
            if (fn[i*4 +: 4] == code && isIn[i]
                && !(cport4w && i == gia_pkg::PIN_CPORT_SEL))
            begin
                acc = acc | cond[i];
            end
        end
        return acc;
    endfunction

    always_comb
    begin
        logic [NPINS-1:0] cond;
        logic [NPINS-1:0] rise;
        logic [NPINS-1:0] fall;
        logic [NPINS-1:0] setEv;
        logic [NPINS-1:0] clrEv;
        logic [7:0]       idx;
        logic             setup;
        logic             commit;
        logic             known;
        logic             cport4w;
        logic             strobeLvl;
        logic             hibEdgeLvl;
        logic             wdogLvl;
        logic [31:0]      rd;

        state_next = state_reg;
        cport4w    = state_reg.ctrl[gia_pkg::CTRL_CPORT_4W];

        // two-stage synchroniser; only syncB feeds logic
        state_next.syncA = pinIn;                                          // [R23]
        state_next.syncB = state_reg.syncA;

        // polarity: one is active high, zero inverts
        cond = state_reg.syncB ^ ~state_reg.polarity;                      // [R6]
        state_next.prevCond = cond;
        rise = cond & ~state_reg.prevCond;
        fall = ~cond & state_reg.prevCond;
        // only input pins raise events
        setEv = (rise | (fall & state_reg.edgeMode)) & state_reg.dir;      // [R4]

        // apb decode; the word index is the address over four
        idx    = paddr[9:2];
        setup  = psel && !penable;
        commit = psel && penable && state_reg.pready;
        known  = 1'b1;
        rd     = 32'h0000_0000;
        case (idx)
            gia_pkg::IDX_STATUS:   rd[NPINS-1:0] = state_reg.flag;
            gia_pkg::IDX_MASK:     rd[NPINS-1:0] = state_reg.mask;
            gia_pkg::IDX_EDGEMODE: rd[NPINS-1:0] = state_reg.edgeMode;
            gia_pkg::IDX_POLARITY: rd[NPINS-1:0] = state_reg.polarity;
            gia_pkg::IDX_DIR:      rd[NPINS-1:0] = state_reg.dir;
            // inputs read the synchronised pin, outputs the driven value
            gia_pkg::IDX_LEVEL:    rd[NPINS-1:0] = (state_reg.syncB & state_reg.dir)
                                                  | (state_reg.level & ~state_reg.dir);
            gia_pkg::IDX_FN_LO:    rd = state_reg.fnSel[31:0];
            gia_pkg::IDX_FN_HI:    rd[NPINS*4-33:0] = state_reg.fnSel[NPINS*4-1:32];
            gia_pkg::IDX_CTRL:     rd[3:0] = state_reg.ctrl;
            gia_pkg::IDX_ALTSTATE: rd[15:0] = {state_reg.hibLatched, state_reg.rstOut_n,
                                               state_reg.auxGate, state_reg.pwrUp,
                                               state_reg.shutdown, state_reg.lowPwr,
                                               state_reg.reg1En, state_reg.hib,
                                               state_reg.cportSel, state_reg.fullRst,
                                               state_reg.adcBitSel, state_reg.adcBit,
                                               state_reg.adcFrmSel, state_reg.adcFrm};
            default:               known = 1'b0;
        endcase

        // answer one cycle after setup; read data frozen at setup
        state_next.pready = setup;
        if (setup)
        begin
            state_next.prdata  = pwrite ? 32'h0000_0000 : rd;
            state_next.pslverr = !known;
        end
        else if (commit)
        begin
            state_next.pslverr = 1'b0;
        end

        // clears: only the bits actually returned by the read are cleared
        clrEv = '0;
        if (commit && !pwrite && idx == gia_pkg::IDX_STATUS)
        begin
            clrEv = state_reg.prdata[NPINS-1:0];                           // [R2]
        end
        if (commit && pwrite)
        begin
            case (idx)
                gia_pkg::IDX_MASK:     state_next.mask = pwdata[NPINS-1:0];
                gia_pkg::IDX_EDGEMODE: state_next.edgeMode = pwdata[NPINS-1:0];
                gia_pkg::IDX_POLARITY: state_next.polarity = pwdata[NPINS-1:0];
                gia_pkg::IDX_DIR:      state_next.dir = pwdata[NPINS-1:0];
                gia_pkg::IDX_LEVEL:
                begin
                    state_next.level = pwdata[NPINS-1:0];
                    clrEv = ~pwdata[NPINS-1:0] & state_reg.dir;            // [R5]
                end
                gia_pkg::IDX_FN_LO:    state_next.fnSel[31:0] = pwdata;
                gia_pkg::IDX_FN_HI:    state_next.fnSel[NPINS*4-1:32] = pwdata[NPINS*4-33:0];
                gia_pkg::IDX_CTRL:     state_next.ctrl = pwdata[3:0];
                default:               state_next.ctrl = state_reg.ctrl;
            endcase
        end

        // sticky flags; a new event beats a clear in the same cycle
        state_next.flag = (state_reg.flag & ~clrEv) | setEv;               // [R23]
        state_next.gpioInt = |(state_next.flag & ~state_next.mask);         // [R1] [R3]

        // fixed-pin audio clock routes
        state_next.adcFrmSel = state_reg.dir[gia_pkg::PIN_ADC_FRAME]
            && state_reg.fnSel[gia_pkg::PIN_ADC_FRAME*4 +: 4] == gia_pkg::FN_ADC_FRM;
        state_next.adcFrm = cond[gia_pkg::PIN_ADC_FRAME];                  // [R7]
        state_next.adcBitSel = 1'b0;
        state_next.adcBit = 1'b0;
        if (state_reg.dir[gia_pkg::PIN_ADC_BIT_A]
            && state_reg.fnSel[gia_pkg::PIN_ADC_BIT_A*4 +: 4] == gia_pkg::FN_ADC_BIT)
        begin
            state_next.adcBitSel = 1'b1;
            state_next.adcBit = cond[gia_pkg::PIN_ADC_BIT_A];              // [R8]
        end
        else if (state_reg.dir[gia_pkg::PIN_ADC_BIT_B]
            && state_reg.fnSel[gia_pkg::PIN_ADC_BIT_B*4 +: 4] == gia_pkg::FN_ADC_BIT)
        begin
            state_next.adcBitSel = 1'b1;
            state_next.adcBit = cond[gia_pkg::PIN_ADC_BIT_B];              // [R8]
        end

        // control port select overrides pin 7 function field
        state_next.cportSel = cport4w ? cond[gia_pkg::PIN_CPORT_SEL] : 1'b0;  // [R11]

        // full reset only passes when software has enabled it
        state_next.fullRst = state_reg.ctrl[gia_pkg::CTRL_FULLRST_EN]      // [R9] [R10]
            && alt_level(gia_pkg::FN_FULLRST, state_reg.fnSel, state_reg.dir, cond, cport4w);

        // edge-driven functions; edges taken on the polarity-adjusted level
        strobeLvl  = alt_level(gia_pkg::FN_STROBE, state_reg.fnSel, state_reg.dir,
                               cond, cport4w);
        hibEdgeLvl = alt_level(gia_pkg::FN_HIB_EDGE, state_reg.fnSel, state_reg.dir,
                               cond, cport4w);
        wdogLvl    = alt_level(gia_pkg::FN_WDOG, state_reg.fnSel, state_reg.dir,
                               cond, cport4w);
        state_next.prevStrobe  = strobeLvl;
        state_next.prevHibEdge = hibEdgeLvl;
        state_next.prevWdog    = wdogLvl;
        state_next.strobe = strobeLvl && !state_reg.prevStrobe             // [R12]
            && state_reg.ctrl[gia_pkg::CTRL_SINK_STRB]
            && state_reg.ctrl[gia_pkg::CTRL_SINK_TRGIO];
        state_next.wdog = wdogLvl && !state_reg.prevWdog;                  // [R16]

        // edge hibernate latches until start-up; a fresh edge wins
        if (hibEdgeLvl && !state_reg.prevHibEdge)
        begin
            state_next.hibLatched = 1'b1;                                  // [R14]
        end
        else if (startupEvent)
        begin
            state_next.hibLatched = 1'b0;                                  // [R15]
        end
        state_next.hib = state_next.hibLatched                             // [R13]
            || alt_level(gia_pkg::FN_HIB_LVL, state_reg.fnSel, state_reg.dir, cond, cport4w);

        // plain routed levels to the power sequencer and converters
        state_next.reg1En = alt_level(gia_pkg::FN_REG1_EN, state_reg.fnSel,     // [R21]
                                      state_reg.dir, cond, cport4w);
        state_next.lowPwr[0] = alt_level(gia_pkg::FN_LOWPWR1, state_reg.fnSel,  // [R18]
                                         state_reg.dir, cond, cport4w);
        state_next.lowPwr[1] = alt_level(gia_pkg::FN_LOWPWR2, state_reg.fnSel,  // [R18]
                                         state_reg.dir, cond, cport4w);
        state_next.lowPwr[2] = alt_level(gia_pkg::FN_LOWPWR3, state_reg.fnSel,  // [R18]
                                         state_reg.dir, cond, cport4w);
        state_next.shutdown = alt_level(gia_pkg::FN_SHUTDOWN, state_reg.fnSel,  // [R19]
                                        state_reg.dir, cond, cport4w);
        state_next.pwrUp = alt_level(gia_pkg::FN_PWRUP, state_reg.fnSel,        // [R22]
                                     state_reg.dir, cond, cport4w);
        state_next.auxGate = alt_level(gia_pkg::FN_AUXGATE, state_reg.fnSel,    // [R20]
                                       state_reg.dir, cond, cport4w);
        // manual reset only pulls the reset outputs; no internal reset here
        state_next.rstOut_n = !alt_level(gia_pkg::FN_MANRST, state_reg.fnSel,   // [R17]
                                         state_reg.dir, cond, cport4w);

        // plain gpio outputs: driven only for output pins in gpio function
        for (int i = 0; i < NPINS; i++)
        begin
            state_next.pinOe[i]  = !state_reg.dir[i]
                && state_reg.fnSel[i*4 +: 4] == gia_pkg::FN_GPIO
                && !(cport4w && i == gia_pkg::PIN_CPORT_SEL);
        end
        state_next.pinOut = state_reg.level;
    end

    // single state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg          <= '0;
            state_reg.mask     <= gia_pkg::RST_MASK;
            state_reg.edgeMode <= gia_pkg::RST_EDGEMODE;
            state_reg.polarity <= gia_pkg::RST_POLARITY;
            state_reg.dir      <= gia_pkg::RST_DIR;
            state_reg.level    <= gia_pkg::RST_LEVEL;
            state_reg.ctrl     <= gia_pkg::RST_CTRL;
            state_reg.rstOut_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign pready             = state_reg.pready;
    assign prdata             = state_reg.prdata;
    assign pslverr            = state_reg.pslverr;
    assign pinOut             = state_reg.pinOut;
    assign pinOe              = state_reg.pinOe;
    assign gpioInt            = state_reg.gpioInt;
    assign adcFrameClockAlt   = state_reg.adcFrm;
    assign adcFrameClockSel   = state_reg.adcFrmSel;
    assign adcBitClockAlt     = state_reg.adcBit;
    assign adcBitClockSel     = state_reg.adcBitSel;
    assign fullResetRequest   = state_reg.fullRst;
    assign controlPortSelect  = state_reg.cportSel;
    assign strobeStart        = state_reg.strobe;
    assign hibernateRequest   = state_reg.hib;
    assign watchdogKick       = state_reg.wdog;
    assign regulatorOneEnable = state_reg.reg1En;
    assign lowPowerRequest    = state_reg.lowPwr;
    assign shutdownRequest    = state_reg.shutdown;
    assign powerUpRequest     = state_reg.pwrUp;
    assign auxConverterGate   = state_reg.auxGate;
    assign resetOutputs_n     = state_reg.rstOut_n;

endmodule

// File: verif/gia_props.sv
// port assertions for the pin event block
`timescale 1ns/1ps
module gia_props (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        gpioInt,
    input wire logic        controlPortSelect,
    input wire logic        fullResetRequest,
    input wire logic        strobeStart,
    input wire logic        watchdogKick
);
    logic [12:0] maskQ;
    logic [3:0]  ctrlQ;
    logic        wrDone;

    // shadows taken where a write lands; two equal samples hide the update lag
    assign wrDone = psel && penable && pready && pwrite;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            maskQ <= 13'h1FFF;
            ctrlQ <= 4'h0;
        end
        else if (wrDone && paddr[9:2] == gia_pkg::IDX_MASK)
            maskQ <= pwdata[12:0];
        else if (wrDone && paddr[9:2] == gia_pkg::IDX_CTRL)
            ctrlQ <= pwdata[3:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_masked;
        maskQ == 13'h1FFF ##1 maskQ == 13'h1FFF;
    endsequence

    a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    a_mask_blocks: assert property (s_masked |-> !gpioInt)
        else $error("masked flag reached interrupt");
    a_cport_gated: assert property (!ctrlQ[1] ##1 !ctrlQ[1] |-> !controlPortSelect)
        else $error("select outside wire mode");
    a_fullrst_gated: assert property (!ctrlQ[0] ##1 !ctrlQ[0] |-> !fullResetRequest)
        else $error("full reset while disabled");
    a_strobe_gated: assert property (strobeStart |-> (&ctrlQ[3:2]) || (&$past(ctrlQ[3:2])))
        else $error("strobe without sink setup");
    a_kick_pulse: assert property (watchdogKick |=> !watchdogKick)
        else $error("kick longer than a cycle");
    a_strobe_pulse: assert property (strobeStart |=> !strobeStart)
        else $error("strobe longer than a cycle");
endmodule

bind gia_core gia_props u_props (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .gpioInt(gpioInt),
    .controlPortSelect(controlPortSelect), .fullResetRequest(fullResetRequest),
    .strobeStart(strobeStart), .watchdogKick(watchdogKick)
);

// File: verif/gia_pin_model.sv
// external pin drivers facing the pin bank
`timescale 1ns/1ps
module gia_pin_model (
    input  wire logic [12:0] pinOut,
    input  wire logic [12:0] pinOe,
    input  wire logic [12:0] pinDrv,
    output logic      [12:0] pinIn
);
    // the device wins where it drives, so a contended line never appears
    assign pinIn = (pinOe & pinOut) | (~pinOe & pinDrv);
endmodule

// File: verif/tb.sv
// self-checking bench for the pin event and alternate input block
`timescale 1ns/1ps
module tb;
    logic        clk, arst_n, psel, penable, pwrite, startupEvent, pready, pslverr, errv;
    logic        gpioInt, frmAlt, frmSel, bitAlt, bitSel, frq, cps, strobeStart, hib;
    logic        watchdogKick, r1e, sdr, pur, aux, rstOut_n;
    logic [2:0]  lpr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [12:0] pinIn, pinOut, pinOe, pinDrv, rv;
    logic [14:0] alt;
    int          n_errors, n_checks, kicks, strobes, p;
    int          codes [13] = '{1, 2, 2, 3, 5, 8, 9, 10, 11, 12, 13, 14, 15};
    int          bits [13]  = '{0, 2, 2, 4, 6, 7, 8, 9, 10, 13, 14, 11, 12};

    assign alt = {rstOut_n, aux, pur, sdr, lpr, r1e, hib, cps, frq, bitSel, bitAlt, frmSel, frmAlt};
    always #20 clk = ~clk;

    gia_core DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .startupEvent(startupEvent),
        .gpioInt(gpioInt), .adcFrameClockAlt(frmAlt), .adcFrameClockSel(frmSel),
        .adcBitClockAlt(bitAlt), .adcBitClockSel(bitSel), .fullResetRequest(frq),
        .controlPortSelect(cps), .strobeStart(strobeStart), .hibernateRequest(hib),
        .watchdogKick(watchdogKick), .regulatorOneEnable(r1e), .lowPowerRequest(lpr),
        .shutdownRequest(sdr), .powerUpRequest(pur), .auxConverterGate(aux),
        .resetOutputs_n(rstOut_n));
    gia_pin_model PINS (.pinOut(pinOut), .pinOe(pinOe), .pinDrv(pinDrv), .pinIn(pinIn));

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    // request held until pready at an edge; a stuck slave ends the run
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20)
        begin
            n_errors++;
            stop_test();
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0);
        chk(rdv, exp);
    endtask

    // pins move, then settle past the synchroniser; pulses are counted
    task automatic drive(input logic [12:0] v);
        @(posedge clk);
        pinDrv <= v;
        repeat (6)
        begin
            @(posedge clk);
            kicks += watchdogKick;
            strobes += strobeStart;
        end
    endtask

    // both halves written so no old function lingers
    task automatic setFn(input int pin, input logic [3:0] code);
        apb(1'h1, gia_pkg::IDX_FN_LO, pin < 8 ? 32'(code) << (4 * pin) : 32'h0);
        apb(1'h1, gia_pkg::IDX_FN_HI, pin < 8 ? 32'h0 : 32'(code) << (4 * (pin - 8)));
    endtask

    function automatic logic [14:0] expAlt(input int code, input int b, input logic lvl, input int q);
        logic [14:0] v;
        v = 15'h4000;
        v[1] = (code == 1);
        v[3] = (code == 2);
        v[b] = v[b] ^ lvl;
        v[0] = lvl && q == 5;
        return v;
    endfunction

    initial
    begin
        {clk, arst_n, psel, penable, pwrite, startupEvent} = 6'h0;
        {paddr, pwdata, pinDrv} = 55'h0;
        void'($urandom(32'hE9EFDB41));
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        rd(gia_pkg::IDX_MASK, 32'h1FFF);
        rd(gia_pkg::IDX_POLARITY, 32'h1FFF);
        rd(gia_pkg::IDX_STATUS, 32'h0);
        apb(1'h0, 8'h30, 32'h0);
        chk(errv, 1'h1);
        rv = 13'($urandom_range(8191, 1));
        drive(rv);
        chk(gpioInt, 1'h0);
        apb(1'h1, gia_pkg::IDX_MASK, 32'h0);
        drive(rv);
        chk(gpioInt, 1'h1);
        rd(gia_pkg::IDX_STATUS, rv);
        rd(gia_pkg::IDX_STATUS, 32'h0);
        chk(gpioInt, 1'h0);
        drive(13'h0);
        rd(gia_pkg::IDX_STATUS, 32'h0);
        apb(1'h1, gia_pkg::IDX_EDGEMODE, 32'h1FFF);
        drive(rv);
        rd(gia_pkg::IDX_STATUS, rv);
        drive(13'h0);
        rd(gia_pkg::IDX_STATUS, rv);
        apb(1'h1, gia_pkg::IDX_EDGEMODE, 32'h0);
        drive(rv);
        apb(1'h1, gia_pkg::IDX_LEVEL, 32'h0);
        rd(gia_pkg::IDX_STATUS, 32'h0);
        drive(13'h0);
        apb(1'h1, gia_pkg::IDX_POLARITY, {19'h0, ~rv});
        drive(13'h0);
        rd(gia_pkg::IDX_STATUS, rv);
        apb(1'h1, gia_pkg::IDX_POLARITY, 32'h1FFF);
        drive(13'h0);
        rd(gia_pkg::IDX_STATUS, 32'h0);
        apb(1'h1, gia_pkg::IDX_CTRL, 32'h1);
        foreach (codes[i])
        begin
            p = (i < 3) ? 5 + i + (i == 2) : $urandom_range(12, 0);
            setFn(p, 4'(codes[i]));
            drive(13'h0);
            chk(alt, expAlt(codes[i], bits[i], 1'h0, p));
            drive(13'(1) << p);
            chk(alt, expAlt(codes[i], bits[i], 1'h1, p));
        end
        setFn(3, gia_pkg::FN_WDOG);
        drive(13'h0);
        kicks = 0;
        repeat (2)
        begin
            drive(13'h0008);
            drive(13'h0);
        end
        chk(kicks, 2);
        setFn(4, gia_pkg::FN_STROBE);
        strobes = 0;
        drive(13'h0010);
        drive(13'h0);
        chk(strobes, 0);
        apb(1'h1, gia_pkg::IDX_CTRL, 32'hD);
        drive(13'h0010);
        drive(13'h0);
        chk(strobes, 1);
        setFn(2, gia_pkg::FN_HIB_EDGE);
        drive(13'h0004);
        chk(hib, 1'h1);
        drive(13'h0);
        chk(hib, 1'h1);
        startupEvent <= 1'h1;
        @(posedge clk);
        startupEvent <= 1'h0;
        drive(13'h0);
        chk(hib, 1'h0);
        setFn(7, gia_pkg::FN_PWRUP);
        apb(1'h1, gia_pkg::IDX_CTRL, 32'h2);
        drive(13'h0080);
        chk(cps, 1'h1);
        drive(13'h0);
        chk(cps, 1'h0);
        stop_test();
    end
endmodule
